// >>> shared/adc_ctrl_defines.svh
// register offsets, field positions, reset values and encodings
// assumes inclusion by bare name from the package and rtl files
// Behaviour
// - gains 1 to 128 from gain field
// - enable 00 powers down and bypasses amplifier
// - enable 01 powers amplifier with programmed gain
// - gains 64/128: analog 32 plus digital scale
// - four rail flags in status register
// - rail detection only while enable bit set
// - reference chosen by two-bit select field
// - reset selects first external reference pair
// - select 10 routes internal reference
// - power 10 always on, 01 off in power-down
// - internal reference off after reset
// - two low-reference flags in status byte
`ifndef ADC_CTRL_DEFINES_SVH
`define ADC_CTRL_DEFINES_SVH
`define ADDR_STATUS        8'h01
`define ADDR_GAIN          8'h03
`define ADDR_REFCTL        8'h05
`define ADDR_EXC1          8'h06
`define GAIN_LSB           0
`define GAIN_MSB           2
`define AMP_EN_LSB         3
`define AMP_EN_MSB         4
`define REFSRC_LSB         2
`define REFSRC_MSB         3
`define REFPWR_LSB         0
`define REFPWR_MSB         1
`define RAIL_EN_BIT        7
`define AMP_OFF            2'h0
`define AMP_ON             2'h1
`define REF_EXT0           2'h0
`define REF_EXT1           2'h1
`define REF_INT            2'h2
`define PWR_OFF            2'h0
`define PWR_ON_PD_OFF      2'h1
`define PWR_ALWAYS         2'h2
`define GAIN_32_CODE       3'h5
`define GAIN_RESET         8'h00
`define REFCTL_RESET       8'h00
`define EXC1_RESET         8'h00
`define RAIL_SHIFT         4
`define VREF_SHIFT         0
`endif

// >>> shared/adc_ctrl_pkg.sv
// types shared by the gain and reference control block
// assumes the defines header is on the include path
`include "adc_ctrl_defines.svh"
package adc_ctrl_pkg;
  typedef struct packed {
    logic pos_out_near_high_rail;
    logic pos_out_near_low_rail;
    logic neg_out_near_high_rail;
    logic neg_out_near_low_rail;
  } rail_s;
  typedef struct packed {
    logic [2:0] analog_gain_code;
    logic [1:0] digital_shift;
    logic       amp_powered;
    logic       amp_bypass;
  } amp_cfg_s;
  typedef struct packed {
    logic [1:0] vref_source_select;
    logic       internal_vref_on;
  } vref_cfg_s;
  typedef enum logic [2:0] {
    ST_RESET = 3'b001,
    ST_RUN   = 3'b010,
    ST_IDLE  = 3'b100
  } mode_e;
endpackage

// >>> rtl/adc_flag_sync.sv
// two-stage synchroniser for the analog monitor flags, one lane per bit
// assumes flags arrive asynchronously from comparators
`timescale 1ns/1ps
`default_nettype none
module adc_flag_sync #(
  parameter int WIDTH = 6
) (
  // clock and reset
  input  wire logic             i_clk,
  input  wire logic             i_sys_rst,
  // flags
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_sync
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] sync;
  } st_s;
  st_s              st_reg;
  st_s              st_next;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_next;
  genvar g;
  // one driver per lane bit, packed into the state copy below
  generate
    for (g = 0; g < WIDTH; g++) begin : g_lane
      assign meta_next[g] = i_async[g];
      assign sync_next[g] = st_reg.meta[g];
    end
  endgenerate
  always_comb begin
    st_next      = st_reg;
    st_next.meta = meta_next;
    st_next.sync = sync_next;
  end
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end
  assign o_sync = st_reg.sync;
endmodule
`default_nettype wire

// >>> rtl/adc_gain_ref_ctrl.sv
// gain and reference configuration with status flags
// assumes a one-cycle register port and asynchronous analog monitor flags
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_defines.svh"
module adc_gain_ref_ctrl (
  // clock and reset
  input  wire logic                   i_clk,
  input  wire logic                   i_sys_rst,
  // register port
  input  wire logic [7:0]             i_addr,
  input  wire logic [7:0]             i_wdata,
  input  wire logic                   i_wr,
  input  wire logic                   i_rd,
  output logic      [7:0]             o_rdata,
  // analog monitors
  input  wire adc_ctrl_pkg::rail_s    i_rail_raw,
  input  wire logic                   i_vref_low0_raw,
  input  wire logic                   i_vref_low1_raw,
  input  wire logic                   i_converting,
  input  wire logic                   i_power_down,
  // analog controls
  output adc_ctrl_pkg::amp_cfg_s      o_amp,
  output adc_ctrl_pkg::vref_cfg_s     o_vref,
  output logic                        o_rail_detect_on,
  output logic                        o_reg_error
);
  typedef struct packed {
    logic [7:0]          gain_reg;
    logic [7:0]          refctl_reg;
    logic [7:0]          exc1_reg;
    adc_ctrl_pkg::rail_s rail;
    logic                vref_low0;
    logic                vref_low1;
    logic [7:0]          rdata;
    logic                err;
    adc_ctrl_pkg::amp_cfg_s  amp;
    adc_ctrl_pkg::vref_cfg_s vref;
    adc_ctrl_pkg::mode_e     mode;
  } st_s;

  st_s st_reg;
  st_s st_next;

  logic [5:0] flags_s;
  logic [2:0] gain_code;
  logic [1:0] amp_en;
  logic [1:0] ref_pwr;

  adc_flag_sync #(.WIDTH(6)) u_sync (
    .i_clk     (i_clk),
    .i_sys_rst (i_sys_rst),
    .i_async   ({i_rail_raw, i_vref_low1_raw, i_vref_low0_raw}),
    .o_sync    (flags_s)
  );

  assign gain_code = st_reg.gain_reg[`GAIN_MSB:`GAIN_LSB];
  assign amp_en    = st_reg.gain_reg[`AMP_EN_MSB:`AMP_EN_LSB];
  assign ref_pwr   = st_reg.refctl_reg[`REFPWR_MSB:`REFPWR_LSB];

  always_comb begin
    st_next = st_reg;
    st_next.err = 1'b0;
    st_next.rdata = 8'h00;
    case (st_reg.mode)
      adc_ctrl_pkg::ST_RESET: begin
        st_next.mode = adc_ctrl_pkg::ST_RUN;
      end
      adc_ctrl_pkg::ST_RUN, adc_ctrl_pkg::ST_IDLE: begin
        st_next.mode = i_converting ? adc_ctrl_pkg::ST_RUN : adc_ctrl_pkg::ST_IDLE;
      end
      default: begin
        st_next.mode = adc_ctrl_pkg::ST_RESET;
      end
    endcase
    // rail flags follow comparators only while detection enabled
    if (st_reg.exc1_reg[`RAIL_EN_BIT]) begin
      st_next.rail = flags_s[5:2];
    end else begin
      st_next.rail = '0;
    end
    // reference monitor live during conversion
    if (i_converting) begin
      st_next.vref_low0 = flags_s[0];
      st_next.vref_low1 = flags_s[1];
    end
    if (i_wr) begin
      case (i_addr)
        `ADDR_GAIN: begin
          st_next.gain_reg = i_wdata;
          // reserved amplifier enable codes flagged
          st_next.err = i_wdata[`AMP_EN_MSB];
        end
        `ADDR_REFCTL: st_next.refctl_reg = i_wdata;
        `ADDR_EXC1:   st_next.exc1_reg   = i_wdata;
        default:      st_next.err        = 1'b1;
      endcase
    end
    if (i_rd) begin
      case (i_addr)
        `ADDR_STATUS: begin
          st_next.rdata = {st_reg.rail, 2'h0, st_reg.vref_low1, st_reg.vref_low0};
        end
        `ADDR_GAIN:   st_next.rdata = st_reg.gain_reg;
        `ADDR_REFCTL: st_next.rdata = st_reg.refctl_reg;
        `ADDR_EXC1:   st_next.rdata = st_reg.exc1_reg;
        default:      st_next.rdata = 8'h00;
      endcase
    end
    // amplifier path
    if (amp_en == `AMP_ON) begin
      st_next.amp.amp_powered = 1'b1;
      st_next.amp.amp_bypass  = 1'b0;
      if (gain_code > `GAIN_32_CODE) begin
        st_next.amp.analog_gain_code = `GAIN_32_CODE;
        st_next.amp.digital_shift    = 2'(gain_code - `GAIN_32_CODE);
      end else begin
        st_next.amp.analog_gain_code = gain_code;
        st_next.amp.digital_shift    = 2'h0;
      end
    end else begin
      st_next.amp.amp_powered      = 1'b0;
      st_next.amp.amp_bypass       = 1'b1;
      st_next.amp.analog_gain_code = 3'h0;
      st_next.amp.digital_shift    = 2'h0;
    end
    // reference routing and power
    // code 10 passes through as the internal reference route
    st_next.vref.vref_source_select = st_reg.refctl_reg[`REFSRC_MSB:`REFSRC_LSB];
    case (ref_pwr)
      `PWR_ALWAYS:    st_next.vref.internal_vref_on = 1'b1;
      `PWR_ON_PD_OFF: st_next.vref.internal_vref_on = ~i_power_down;
      default:        st_next.vref.internal_vref_on = 1'b0;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      st_reg <= '{gain_reg: `GAIN_RESET, refctl_reg: `REFCTL_RESET,
                  exc1_reg: `EXC1_RESET, rail: '0, vref_low0: 1'b0,
                  vref_low1: 1'b0, rdata: 8'h00, err: 1'b0,
                  amp: '{analog_gain_code: 3'h0, digital_shift: 2'h0,
                         amp_powered: 1'b0, amp_bypass: 1'b1},
                  vref: '{vref_source_select: `REF_EXT0, internal_vref_on: 1'b0},
                  mode: adc_ctrl_pkg::ST_RESET};
    end else begin
      st_reg <= st_next;
    end
  end

  assign o_rdata          = st_reg.rdata;
  assign o_amp            = st_reg.amp;
  assign o_vref           = st_reg.vref;
  assign o_rail_detect_on = st_reg.exc1_reg[`RAIL_EN_BIT];
  assign o_reg_error      = st_reg.err;

  // checks
  a_high_gain_split: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (amp_en == `AMP_ON && gain_code == 3'h7) |=>
    (o_amp.analog_gain_code == 3'h5 && o_amp.digital_shift == 2'h2))
    else $error("gain 128 not split into 32 and scale 4");
  a_bypass_off: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (amp_en == `AMP_OFF) |=> (o_amp.amp_bypass && !o_amp.amp_powered))
    else $error("amplifier not bypassed at enable 00");
  a_amp_active: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (amp_en == `AMP_ON && gain_code < 3'h6) |=>
    (o_amp.amp_powered && o_amp.analog_gain_code == $past(gain_code)))
    else $error("programmed gain not applied");
  a_rail_gated: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !st_reg.exc1_reg[`RAIL_EN_BIT] |=> (st_reg.rail == '0))
    else $error("rail flag set with detection off");
  a_status_read: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_rd && i_addr == `ADDR_STATUS) |=>
    (o_rdata[7:4] == $past(st_reg.rail) && o_rdata[0] == $past(st_reg.vref_low0)))
    else $error("status read mismatch");
  a_ref_select: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (st_reg.refctl_reg[3:2] == `REF_INT) |=>
    (o_vref.vref_source_select == `REF_INT))
    else $error("internal reference not routed");
  a_ref_power: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (ref_pwr == `PWR_ON_PD_OFF && i_power_down) |=> !o_vref.internal_vref_on)
    else $error("reference on during power-down");
  a_reset_state: assert property (@(posedge i_clk)
    i_sys_rst |=> (o_vref == '0 && o_amp.amp_bypass))
    else $error("reset state wrong");
  a_ref_low_hold: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !i_converting |=> $stable(st_reg.vref_low1))
    else $error("reference flag moved outside conversion");
  a_gain_store: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    (i_wr && i_addr == `ADDR_GAIN) |=> ##1 (o_amp.amp_powered == (amp_en == `AMP_ON)))
    else $error("gain write not applied");
  c_gain_128: cover property (@(posedge i_clk) amp_en == `AMP_ON && gain_code == 3'h7);
  c_bypass: cover property (@(posedge i_clk) o_amp.amp_bypass && !i_sys_rst);
  c_int_ref: cover property (@(posedge i_clk) o_vref.internal_vref_on);
  c_rail: cover property (@(posedge i_clk) st_reg.rail != '0);
endmodule
`default_nettype wire

// >>> verification/adc_host_model.sv
// host side of the register port: one-cycle write and read strobes
// assumes the bench calls its tasks and checks read data itself
`timescale 1ns/1ps
`default_nettype none
module adc_host_model (
  // clock
  input  wire logic       i_clk,
  // register port
  output logic      [7:0] o_addr,
  output logic      [7:0] o_wdata,
  output logic            o_wr,
  output logic            o_rd
);
  initial begin
    o_addr  = 8'h00;
    o_wdata = 8'h00;
    o_wr    = 1'b0;
    o_rd    = 1'b0;
  end
  // strobe held through the taking edge, dropped right after it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    o_addr  <= a;
    o_wdata <= d;
    o_wr    <= 1'b1;
    @(posedge i_clk);
    o_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge i_clk);
    o_addr <= a;
    o_rd   <= 1'b1;
    @(posedge i_clk);
    o_rd   <= 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> verification/test_adc_gain_and_reference_control.sv
// self-checking bench for the gain and reference control block
// assumes the defines header is on the include path
`timescale 1ns/1ps
`default_nettype none
`include "adc_ctrl_defines.svh"
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin bad_count++; \
  $display("[ERR] %s exp %h got %h", n, e, s); end end
module test_adc_gain_and_reference_control;
  logic                    clk = 1'b0;
  logic                    rst = 1'b1;
  logic                    pd = 1'b0;
  logic                    conv = 1'b0;
  logic                    l0 = 1'b0;
  logic                    l1 = 1'b0;
  adc_ctrl_pkg::rail_s     rail = '0;
  adc_ctrl_pkg::amp_cfg_s  amp;
  adc_ctrl_pkg::vref_cfg_s vref;
  logic [7:0]              addr, wdata, rdata, top, e;
  logic                    wr, rd, err, det;
  logic                    rd_d = 1'b0;
  logic [7:0]              exp_q[$];
  int                      bad_count = 0;
  int                      check_count = 0;
  always #12.5 clk = ~clk;
  adc_host_model host (.i_clk(clk), .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd));
  adc_gain_ref_ctrl dut (
    .i_clk(clk), .i_sys_rst(rst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .i_rail_raw(rail), .i_vref_low0_raw(l0), .i_vref_low1_raw(l1),
    .i_converting(conv), .i_power_down(pd), .o_amp(amp), .o_vref(vref),
    .o_rail_detect_on(det), .o_reg_error(err));
  // read data stands only in the cycle after the strobe
  always @(posedge clk) begin
    if (rd_d) begin
      top = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx;
      `CHK("rdata", top, rdata)
    end
    rd_d <= rd;
  end
  task automatic report_and_stop();
    if (bad_count == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] x);
    exp_q.push_back(x);
    host.rd(a);
  endtask
  task automatic err_chk(input logic [7:0] a, input logic [7:0] d, input logic x);
    logic seen;
    seen = 1'b0;
    host.wr(a, d);
    repeat (3) begin
      @(posedge clk);
      seen = seen | err;
    end
    `CHK("reg_error", x, seen)
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    report_and_stop();
  end
  initial begin
    void'($urandom(71));
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    cyc(1);
    `CHK("vref_rst", 3'h0, vref)
    `CHK("bypass_rst", 1'b1, amp.amp_bypass)
    rd_chk(`ADDR_REFCTL, 8'h00);
    rd_chk(`ADDR_GAIN, 8'h00);
    rd_chk(8'h10, 8'h00);
    for (int g = 0; g < 8; g++) begin
      host.wr(`ADDR_GAIN, {3'b000, 2'b01, g[2:0]});
      cyc(3);
      e = {1'b0, (g > 5) ? 3'h5 : g[2:0], (g > 5) ? 2'(g - 5) : 2'h0, 2'b10};
      `CHK("amp", e[6:0], amp)
      rd_chk(`ADDR_GAIN, {3'b000, 2'b01, g[2:0]});
    end
    host.wr(`ADDR_GAIN, 8'h00);
    cyc(3);
    `CHK("amp_off", 7'h01, amp)
    err_chk(`ADDR_GAIN, 8'h08, 1'b0);
    err_chk(8'h02, 8'h10, 1'b1);
    err_chk(8'h07, 8'h18, 1'b1);
    err_chk(`ADDR_STATUS, 8'hff, 1'b1);
    err_chk(8'h20, 8'h55, 1'b1);
    for (int s = 0; s < 3; s++)
      for (int p = 0; p < 3; p++)
        for (int d = 0; d < 2; d++) begin
          pd <= d[0];
          host.wr(`ADDR_REFCTL, {4'h0, s[1:0], p[1:0]});
          cyc(3);
          e = {5'h00, s[1:0], (p == 2) || (p == 1 && d == 0)};
          `CHK("vref", e[2:0], vref)
          rd_chk(`ADDR_REFCTL, {4'h0, s[1:0], p[1:0]});
        end
    // internal reference off, no excitation used, so no start-up wait
    host.wr(`ADDR_REFCTL, 8'h00);
    cyc(3);
    `CHK("vref_ext0", 3'h0, vref)
    repeat (4) begin
      conv <= 1'b1;
      rail <= 4'($urandom());
      l0   <= 1'($urandom());
      l1   <= 1'($urandom());
      host.wr(`ADDR_EXC1, 8'h00);
      cyc(5);
      `CHK("rail_on", 1'b0, det)
      rd_chk(`ADDR_STATUS, {4'h0, 2'b00, l1, l0});
      host.wr(`ADDR_EXC1, 8'h80);
      cyc(5);
      `CHK("rail_on", 1'b1, det)
      e = {rail, 2'b00, l1, l0};
      rd_chk(`ADDR_STATUS, e);
      conv <= 1'b0;
      l0   <= ~l0;
      l1   <= ~l1;
      cyc(5);
      rd_chk(`ADDR_STATUS, e);
    end
    cyc(4);
    if (exp_q.size() != 0)
      bad_count++;
    report_and_stop();
  end
endmodule
`default_nettype wire
